// >>> design/fcc_top.sv
// Five channel counter timer with its AHB-Lite register slave.
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "fcc_cfg.svh"

module fcc_top
#(
    parameter int NUM_CH = `FCC_NUM_CH,
    parameter int CNT_W = `FCC_CNT_W,
    parameter int DIV_W = `FCC_DIV_W
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NUM_CH-1:0] ct_clk_in,
    input wire logic [NUM_CH-1:0] ct_gate_in,
    output logic [NUM_CH-1:0] ct_out
);
    import fcc_pkg::*;

    // ----------------------------------------------------------------
    // State of the whole block
    // ----------------------------------------------------------------

    typedef struct packed {
        logic [NUM_CH-1:0] en;
        logic [NUM_CH-1:0] ext;
        logic [NUM_CH-1:0] pol;
        fcc_mode_type [NUM_CH-1:0] mode;
        fcc_gate_type [NUM_CH-1:0] gate;
        fcc_state_type [NUM_CH-1:0] st;
        logic [NUM_CH-1:0][DIV_W-1:0] div;
        logic [NUM_CH-1:0][6:0] duty;
        logic [NUM_CH-1:0][CNT_W-1:0] load;
        logic [NUM_CH-1:0][CNT_W-1:0] count;
        logic [NUM_CH-1:0][CNT_W-1:0] capt;
        logic [NUM_CH-1:0] restart;
        logic [NUM_CH-1:0] out;
        logic wr_pend;
        logic [2:0] wch;
        logic [2:0] widx;
        logic [31:0] hrdata;
        logic rdy;
        logic resp;
    } fcc_top_state_type;

    // Builds the reset image: idle channels, outputs at inactive high.
    function automatic fcc_top_state_type rst_state();
        fcc_top_state_type s;
        s = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            s.div[i] = DIV_W'(`FCC_DIV_RST);
            s.duty[i] = `FCC_DUTY_RST;
            s.out[i] = 1'b1;
        end
        s.rdy = 1'b1;
        return s;
    endfunction

    localparam fcc_top_state_type RST_STATE = rst_state();

    fcc_top_state_type cur_reg;
    fcc_top_state_type cur_next;

    logic [NUM_CH-1:0] c_lvl;
    logic [NUM_CH-1:0] c_rise;
    logic [NUM_CH-1:0] g_lvl;
    logic [NUM_CH-1:0] g_rise;
    logic [NUM_CH-1:0] g_fall;
    logic [NUM_CH-1:0] div_tick;
    logic [NUM_CH-1:0] div_on;
    logic [NUM_CH-1:0] c_fall_unused;

    // ----------------------------------------------------------------
    // Pin synchronisers and per channel dividers
    // ----------------------------------------------------------------

    // Clock and gate pins of every channel cross into mclk here.
    fcc_sync
    #(
        .W(2 * NUM_CH)
    )
    u_sync
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .din({ct_gate_in, ct_clk_in}),
        .lvl({g_lvl, c_lvl}),
        .rise({g_rise, c_rise}),
        .fall({g_fall, c_fall_unused})
    );

    // Each channel has its own divider so rates stay independent.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_div
            fcc_divider
            #(
                .DIV_W(DIV_W)
            )
            u_div
            (
                .mclk(mclk),
                .rst_n(rst_n),
                .restart(cur_reg.restart[gi]),
                .div(cur_reg.div[gi]),
                .duty(cur_reg.duty[gi]),
                .tick(div_tick[gi]),
                .phase_on(div_on[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Channel engines and register slave
    // ----------------------------------------------------------------

    always_comb
    begin
        logic lvl_ok;
        logic edge_gate;
        logic edge_hit;
        logic stop_hit;
        logic tick;
        logic act;
        logic shot;
        logic [2:0] rch;
        logic [31:0] rd;
        lvl_ok = 1'b1;
        edge_gate = 1'b0;
        edge_hit = 1'b0;
        stop_hit = 1'b0;
        tick = 1'b0;
        act = 1'b0;
        shot = 1'b0;
        rch = '0;
        rd = '0;
        cur_next = cur_reg;
        cur_next.restart = '0;
        cur_next.wr_pend = 1'b0;

        // Every channel runs the same engine on its own fields.
        for (int i = 0; i < NUM_CH; i++)
        begin
            lvl_ok = 1'b1;
            if (cur_reg.gate[i] == GATE_LOW)
                lvl_ok = ~g_lvl[i];
            else if (cur_reg.gate[i] == GATE_HIGH)
                lvl_ok = g_lvl[i];
            edge_gate = (cur_reg.gate[i] == GATE_FALL) || (cur_reg.gate[i] == GATE_RISE);
            edge_hit = ((cur_reg.gate[i] == GATE_FALL) && g_fall[i])
                || ((cur_reg.gate[i] == GATE_RISE) && g_rise[i]);
            stop_hit = ((cur_reg.gate[i] == GATE_FALL) && g_rise[i])
                || ((cur_reg.gate[i] == GATE_RISE) && g_fall[i]);
            tick = cur_reg.ext[i] ? c_rise[i] : (div_tick[i] && !cur_reg.restart[i]);
            shot = (cur_reg.mode[i] == MODE_SHOT) || (cur_reg.mode[i] == MODE_RSHOT);
            act = 1'b0;
            case (cur_reg.st[i])
                ST_ARMED:
                begin
                    // An absent gate fires a one-shot at once, a level gate once it is at its level.
                    if (edge_hit || (!edge_gate && lvl_ok && shot))
                    begin
                        cur_next.st[i] = ST_ACTIVE;
                        cur_next.restart[i] = 1'b1;
                        if (cur_reg.mode[i] == MODE_CONT)
                            cur_next.count[i] = '0;
                    end
                end
                ST_ACTIVE:
                begin
                    case (cur_reg.mode[i])
                        MODE_EVENT, MODE_FREQ:
                        begin
                            // Counts only inside the gate's active part.
                            if (tick && lvl_ok)
                                cur_next.count[i] = cur_reg.count[i] + CNT_W'(1);
                        end
                        MODE_UPDN:
                        begin
                            // The gate pin is the direction, whatever its type.
                            if (tick && g_lvl[i])
                                cur_next.count[i] = cur_reg.count[i] + CNT_W'(1);
                            else if (tick)
                                cur_next.count[i] = cur_reg.count[i] - CNT_W'(1);
                        end
                        MODE_EDGE:
                        begin
                            // The opposite gate edge ends the interval.
                            if (stop_hit)
                                cur_next.st[i] = ST_DONE;
                            else if (tick)
                                cur_next.count[i] = cur_reg.count[i] + CNT_W'(1);
                        end
                        MODE_CONT:
                        begin
                            // Each new start edge stores the interval and restarts.
                            if (edge_hit)
                            begin
                                cur_next.capt[i] = cur_reg.count[i];
                                cur_next.count[i] = '0;
                            end
                            else if (tick)
                                cur_next.count[i] = cur_reg.count[i] + CNT_W'(1);
                        end
                        MODE_RATE:
                        begin
                            // Pulses run only while the gate is at its level.
                            act = lvl_ok && (cur_reg.ext[i] ? c_lvl[i] : div_on[i]);
                            if (tick && lvl_ok)
                                cur_next.count[i] = cur_reg.count[i] + CNT_W'(1);
                        end
                        MODE_SHOT, MODE_RSHOT:
                        begin
                            // A full period of active output, then stop or rearm.
                            act = 1'b1;
                            if (tick && (cur_reg.mode[i] == MODE_SHOT))
                                cur_next.st[i] = ST_DONE;
                            else if (tick)
                                cur_next.st[i] = ST_ARMED;
                        end
                        default:
                        begin
                            act = 1'b0;
                        end
                    endcase
                end
                default:
                begin
                    // Idle and done channels ignore clock and gate pins.
                    act = 1'b0;
                end
            endcase
            cur_next.out[i] = cur_reg.pol[i] ? act : ~act;
        end

        // Data phase of a write that was accepted one cycle earlier.
        if (cur_reg.wr_pend && (cur_reg.wch < 3'(NUM_CH)))
        begin
            case (cur_reg.widx)
                `FCC_IDX_CTRL:
                begin
                    cur_next.en[cur_reg.wch] = hwdata[`FCC_CTRL_EN];
                    cur_next.mode[cur_reg.wch] = fcc_mode_type'(hwdata[`FCC_CTRL_MODE]);
                    cur_next.gate[cur_reg.wch] = fcc_gate_type'(hwdata[`FCC_CTRL_GATE]);
                    cur_next.ext[cur_reg.wch] = hwdata[`FCC_CTRL_EXT];
                    cur_next.pol[cur_reg.wch] = hwdata[`FCC_CTRL_POL];
                    cur_next.capt[cur_reg.wch] = '0;
                    cur_next.restart[cur_reg.wch] = 1'b1;
                    cur_next.count[cur_reg.wch] = '0;
                    if (!hwdata[`FCC_CTRL_EN])
                        cur_next.st[cur_reg.wch] = ST_IDLE;
                    else if (fcc_mode_type'(hwdata[`FCC_CTRL_MODE]) == MODE_UPDN)
                    begin
                        cur_next.st[cur_reg.wch] = ST_ACTIVE;
                        cur_next.count[cur_reg.wch] = cur_reg.load[cur_reg.wch];
                    end
                    else if (hwdata[`FCC_CTRL_MODE] >= 3'(MODE_EDGE)
                        && fcc_mode_type'(hwdata[`FCC_CTRL_MODE]) != MODE_RATE)
                        cur_next.st[cur_reg.wch] = ST_ARMED;
                    else if ((fcc_gate_type'(hwdata[`FCC_CTRL_GATE]) == GATE_FALL)
                        || (fcc_gate_type'(hwdata[`FCC_CTRL_GATE]) == GATE_RISE))
                        cur_next.st[cur_reg.wch] = ST_ARMED;
                    else
                        cur_next.st[cur_reg.wch] = ST_ACTIVE;
                end
                `FCC_IDX_DIVLO:
                begin
                    cur_next.div[cur_reg.wch][31:0] = hwdata;
                end
                `FCC_IDX_DIVHI:
                begin
                    cur_next.div[cur_reg.wch][DIV_W-1:32] = hwdata[DIV_W-33:0];
                end
                `FCC_IDX_DUTY:
                begin
                    cur_next.duty[cur_reg.wch] = hwdata[`FCC_DUTY_F];
                end
                `FCC_IDX_LOAD:
                begin
                    cur_next.load[cur_reg.wch] = hwdata[CNT_W-1:0];
                end
                default:
                begin
                    cur_next.wr_pend = 1'b0;
                end
            endcase
        end

        // Address phase: note writes, and answer reads from the fresh state.
        if (hsel && hready && htrans[1])
        begin
            cur_next.wr_pend = hwrite && (hsize == `FCC_HSIZE_WORD);
            cur_next.wch = haddr[`FCC_ADDR_CH];
            cur_next.widx = haddr[`FCC_ADDR_IDX];
            rch = haddr[`FCC_ADDR_CH];
            if (!hwrite && (rch < 3'(NUM_CH)))
            begin
                case (haddr[`FCC_ADDR_IDX])
                    `FCC_IDX_CTRL:
                        rd = {23'h000000, cur_next.pol[rch], cur_next.ext[rch],
                            3'(cur_next.gate[rch]), 3'(cur_next.mode[rch]), cur_next.en[rch]};
                    `FCC_IDX_DIVLO:
                        rd = cur_next.div[rch][31:0];
                    `FCC_IDX_DIVHI:
                        rd = 32'(cur_next.div[rch][DIV_W-1:32]);
                    `FCC_IDX_DUTY:
                        rd = 32'(cur_next.duty[rch]);
                    `FCC_IDX_COUNT:
                        rd = (cur_next.mode[rch] == MODE_CONT) ? 32'(cur_next.capt[rch])
                            : 32'(cur_next.count[rch]);
                    `FCC_IDX_LOAD:
                        rd = 32'(cur_next.load[rch]);
                    `FCC_IDX_STAT:
                        rd = {28'h0000000, cur_next.out[rch], g_lvl[rch], 2'(cur_next.st[rch])};
                    default:
                        rd = '0;
                endcase
            end
            if (!hwrite)
                cur_next.hrdata = rd;
        end

        // Every transfer completes at once with an OKAY answer.
        cur_next.rdy = 1'b1;
        cur_next.resp = 1'b0;
    end

    // ----------------------------------------------------------------
    // State register and outputs
    // ----------------------------------------------------------------

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cur_reg <= RST_STATE;
        else
            cur_reg <= cur_next;
    end

    // All outputs come straight from the state register.
    assign hrdata = cur_reg.hrdata;
    assign hreadyout = cur_reg.rdy;
    assign hresp = cur_reg.resp;
    assign ct_out = cur_reg.out;
endmodule

// >>> common/fcc_cfg.svh
// Configuration macros for the five channel counter timer.
// Function
// - Five independent 32-bit counters, numbered 0 to 4.
// - Each channel: clock input, gate input, pulse output.
// - Configuration element n selects counter channel n.
// - Internal source uses the fixed 48 MHz base.
// - External source advances on clock input rising edge.
// - Divider 2 to 4,294,967,296 divides the base; at 2 the code ticks once per 20 MHz system cycle, not at 24 MHz.
// - Gate none: run at once after software start; the code leaves MODE_EDGE and MODE_CONT armed, never running.
// - Low level gate: run while gate is low.
// - High level gate: run while gate is high.
// - Falling edge gate: start on high-to-low transition.
// - Rising edge gate: start on low-to-high transition.
// - Selectable output polarity: active low or high.
// - Duty cycle is active percentage of the period.
// - Eight modes, polarity selectable in every mode.
// - Event count: count clock edges while gate active.
// - Event counter wraps to zero and keeps counting.
// - Up/down: gate high counts up, low counts down.
// - Up/down ignores gate type; gate sets direction.
// - Measuring channel counts only during active gate pulse.
// - Rate generation pulses only while gate is active.
// - One-shot emits one pulse, then ignores everything.
`ifndef FCC_CFG_SVH
`define FCC_CFG_SVH

// Channel count and widths.
`define FCC_NUM_CH 5
`define FCC_CNT_W 32
`define FCC_DIV_W 33

// Internal time base and the system clock rate, both in MHz.
`define FCC_BASE_MHZ 6'h30
`define FCC_MCLK_MHZ 6'h14
`define FCC_PCT_FULL 7'h64

// Reset values of divider and duty cycle.
`define FCC_DIV_RST 33'h000000002
`define FCC_DUTY_RST 7'h32

// Address fields: each channel owns a 32 byte window of word registers.
`define FCC_ADDR_CH 7:5
`define FCC_ADDR_IDX 4:2
`define FCC_HSIZE_WORD 3'h2

// Register indices within a channel window.
`define FCC_IDX_CTRL 3'h0
`define FCC_IDX_DIVLO 3'h1
`define FCC_IDX_DIVHI 3'h2
`define FCC_IDX_DUTY 3'h3
`define FCC_IDX_COUNT 3'h4
`define FCC_IDX_LOAD 3'h5
`define FCC_IDX_STAT 3'h6

// Control register fields.
`define FCC_CTRL_EN 0
`define FCC_CTRL_MODE 3:1
`define FCC_CTRL_GATE 6:4
`define FCC_CTRL_EXT 7
`define FCC_CTRL_POL 8
`define FCC_DUTY_F 6:0

`endif

// >>> common/fcc_pkg.sv
// Types shared by the counter timer design files.
package fcc_pkg;

    // Operating modes of one channel.
    typedef enum logic [2:0] {
        MODE_EVENT = 3'b000,
        MODE_UPDN = 3'b001,
        MODE_FREQ = 3'b010,
        MODE_EDGE = 3'b011,
        MODE_CONT = 3'b100,
        MODE_RATE = 3'b101,
        MODE_SHOT = 3'b110,
        MODE_RSHOT = 3'b111
    } fcc_mode_type;

    // Gate qualification types.
    typedef enum logic [2:0] {
        GATE_NONE = 3'b000,
        GATE_LOW = 3'b001,
        GATE_HIGH = 3'b010,
        GATE_FALL = 3'b011,
        GATE_RISE = 3'b100
    } fcc_gate_type;

    // Run state of one channel.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_ACTIVE = 2'b10,
        ST_DONE = 2'b11
    } fcc_state_type;

endpackage

// >>> design/fcc_sync.sv
// Two flip-flop synchroniser with edge detection for external pins.
`timescale 1ns/1ns

module fcc_sync
#(
    parameter int W = 1
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } fcc_sync_state_type;

    fcc_sync_state_type cur_reg;
    fcc_sync_state_type cur_next;

    // Shift the pins through two stages, then keep one more for edges.
    always_comb
    begin
        cur_next.s1 = din;
        cur_next.s2 = cur_reg.s1;
        cur_next.s3 = cur_reg.s2;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cur_reg <= '0;
        else
            cur_reg <= cur_next;
    end

    // Only the second and third stages feed logic.
    assign lvl = cur_reg.s2;
    assign rise = cur_reg.s2 & ~cur_reg.s3;
    assign fall = ~cur_reg.s2 & cur_reg.s3;
endmodule

// >>> design/fcc_divider.sv
// Fractional divider that turns the base rate into count ticks.
`timescale 1ns/1ns
`include "fcc_cfg.svh"

module fcc_divider
#(
    parameter int DIV_W = `FCC_DIV_W,
    parameter int ACC_W = 40
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [DIV_W-1:0] div,
    input wire logic [6:0] duty,
    output logic tick,
    output logic phase_on
);
    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic tick;
    } fcc_div_state_type;

    fcc_div_state_type cur_reg;
    fcc_div_state_type cur_next;
    logic [ACC_W-1:0] limit;
    logic [ACC_W-1:0] sum;

    // One output period spans div base cycles, scaled to system cycles.
    assign limit = ACC_W'(div) * ACC_W'(`FCC_MCLK_MHZ);
    assign sum = cur_reg.acc + ACC_W'(`FCC_BASE_MHZ);

    // Advance the phase by the base rate and wrap once per period.
    always_comb
    begin
        cur_next = cur_reg;
        cur_next.tick = 1'b0;
        if (restart)
            cur_next.acc = '0;
        else if (sum >= limit)
        begin
            cur_next.acc = sum - limit;
            cur_next.tick = 1'b1;
        end
        else
            cur_next.acc = sum;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cur_reg <= '0;
        else
            cur_reg <= cur_next;
    end

    // The phase is active for the programmed percentage of the period.
    assign tick = cur_reg.tick;
    assign phase_on = ((ACC_W+7)'(cur_reg.acc) * (ACC_W+7)'(`FCC_PCT_FULL))
        < ((ACC_W+7)'(duty) * (ACC_W+7)'(limit));
endmodule

// >>> design/fcc_top_fix.sv
// Unused.

// >>> tb/fcc_top_sva.sv
// Concurrent checks on the ports of the five channel counter timer.
`timescale 1ns/1ns

module fcc_top_sva
#(
    parameter int NUM_CH = 5
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [NUM_CH-1:0] ct_out
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic tk;
    logic wr_dp;
    logic [31:0] wr_a;
    logic [NUM_CH-1:0] started;

    // An address phase is taken on this edge.
    assign tk = hsel && hready && htrans[1];

    // Tracks the write data phase and channels that ever saw a control write.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_dp <= 1'b0;
            wr_a <= 32'h0;
            started <= '0;
        end
        else
        begin
            wr_dp <= tk && hwrite && hsize == 3'h2;
            wr_a <= haddr;
            if (tk && hwrite && haddr[4:2] == 3'h0 && haddr[7:5] < 3'h5)
            begin
                started[haddr[7:5]] <= 1'b1;
            end
        end
    end

    sequence s_rd;
        tk && !hwrite;
    endsequence

    sequence s_wr_load;
        wr_dp && wr_a[4:2] == 3'h5 && wr_a[7:5] < 3'h5;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave answered with an error response");
    a_rd_hold: assert property (!(tk && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
    a_bad_chan: assert property (s_rd ##0 (haddr[7:5] > 3'h4) |=> hrdata == 32'h0)
        else $error("unmapped channel read not zero");
    a_bad_index: assert property (s_rd ##0 (haddr[4:2] == 3'h7) |=> hrdata == 32'h0)
        else $error("unmapped register read not zero");
    a_load_back: assert property (s_wr_load ##1 (s_rd ##0 haddr[7:2] == wr_a[7:2])
        |=> hrdata == $past(hwdata, 2)) else $error("preload readback wrong");
    a_out_idle: assert property (&(ct_out | started))
        else $error("output moved on an unconfigured channel");
    a_rst_idle: assert property ($rose(rst_n) |-> ct_out == {NUM_CH{1'b1}})
        else $error("outputs not idle high after reset");
endmodule

// >>> tb/fcc_pins.sv
// Model of the external clock and gate sources wired to the channels.
`timescale 1ns/1ns

module fcc_pins
(
    input wire logic mclk,
    output logic [4:0] ct_clk_in,
    output logic [4:0] ct_gate_in
);
    // Clocks stand still low outside bursts; gates start low.
    initial
    begin
        ct_clk_in = 5'h00;
        ct_gate_in = 5'h00;
    end

    // Sets one gate level, then gives n clock pulses of eight system cycles each.
    task automatic burst(input int ch, input int n, input logic g);
        @(posedge mclk);
        ct_gate_in[ch] <= g;
        repeat (4) @(posedge mclk);
        repeat (n)
        begin
            ct_clk_in[ch] <= 1'b1;
            repeat (4) @(posedge mclk);
            ct_clk_in[ch] <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask
endmodule

// >>> tb/tb_fcc_top.sv
// Self-checking bench for the five channel counter timer.
`timescale 1ns/1ns

module tb_fcc_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [4:0] ct_clk_in;
    logic [4:0] ct_gate_in;
    logic [4:0] ct_out;
    logic [31:0] seed = 32'hB80B;
    logic [31:0] rd;
    logic [31:0] v;
    int fails = 0;
    int checked = 0;
    int hi;
    int up;
    int dn;

    // The 20 MHz system clock.
    always #25 mclk = ~mclk;

    fcc_top dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ct_clk_in(ct_clk_in),
        .ct_gate_in(ct_gate_in ^ {3'h0, ct_out[0], 1'b0}), .ct_out(ct_out));
    fcc_pins pins (.mclk(mclk), .ct_clk_in(ct_clk_in), .ct_gate_in(ct_gate_in));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected event count for gate type none, low level or high level.
    function automatic logic [31:0] exp_ev(input int g, input int n_hi, input int n_lo);
        return 32'((g != 1 ? n_hi : 0) + (g != 2 ? n_lo : 0));
    endfunction

    // One single word transfer; read data lands in rd.
    task automatic bus(input logic w, input int ch, input int idx, input logic [31:0] d);
        haddr <= 32'(ch * 32 + idx * 4);
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int top);
        checked++;
        if (got < lo || got > top)
        begin
            fails++;
            $display("ERROR %0t got %h exp %h..%h", $time, got, lo, top);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        hsel <= 1'b1;
        for (int c = 0; c < 7; c++)
        begin
            bus(1'b0, c, 1, 32'h0);
            chk(rd, c < 5 ? 32'h2 : 32'h0);
            bus(1'b0, c, 3, 32'h0);
            chk(rd, c < 5 ? 32'h32 : 32'h0);
        end
        bus(1'b0, 2, 7, 32'h0);
        chk(rd, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 6; i++)
        begin
            hi = int'(xs() % 5);
            v = xs();
            bus(1'b1, hi, 5, v);
            bus(1'b0, hi, 5, 32'h0);
            chk(rd, v);
        end
        $display("preload readback done");
        for (int g = 0; g < 3; g++)
        begin
            up = 1 + int'(xs() % 6);
            dn = 1 + int'(xs() % 6);
            bus(1'b1, g + 1, 0, 32'(32'h81 | (g << 4) | (g == 2 ? 10 : g * 4)));
            pins.burst(g + 1, up, 1'b1);
            pins.burst(g + 1, dn, 1'b0);
            repeat (8) @(posedge mclk);
            bus(1'b0, g + 1, 4, 32'h0);
            chk(rd, exp_ev(g, up, dn));
            $display("event count with gate type %0d done", g);
        end
        v = 32'd100 + (xs() % 1000);
        bus(1'b1, 4, 5, v);
        bus(1'b1, 4, 0, 32'hB3);
        pins.burst(4, 3, 1'b1);
        pins.burst(4, 2, 1'b0);
        repeat (8) @(posedge mclk);
        bus(1'b0, 4, 4, 32'h0);
        chk(rd, v + 32'd1);
        $display("up down count done");
        bus(1'b1, 1, 0, 32'hA5);
        bus(1'b1, 0, 1, 32'd48);
        bus(1'b1, 0, 0, 32'h14D);
        for (int k = 0; k < 2; k++)
        begin
            pins.burst(0, 0, 1'b0);
            chk({31'h0, ct_out[0]}, 32'h0);
            fork
                pins.burst(1, 4, 1'b0);
            join_none
            pins.burst(0, 0, 1'b1);
            hi = 0;
            repeat (60)
            begin
                @(posedge mclk);
                hi += (ct_out[0] === 1'b1) ? 1 : 0;
            end
            chk_rng(hi, k == 0 ? 18 : 0, k == 0 ? 22 : 0);
        end
        bus(1'b0, 1, 4, 32'h0);
        chk_rng(int'(rd), 2, 3);
        $display("one shot done");
        close_out();
    end

    // Cuts a hung run short.
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        close_out();
    end
endmodule

bind fcc_top fcc_top_sva #(.NUM_CH(NUM_CH)) sva (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ct_out(ct_out));
